// [design/kwi_pkg.sv]
package kwi_pkg;

	// Pull device steering for one group of pins
	typedef struct packed {
		logic [7:0] pull_up_en;
		logic [7:0] pull_down_en;
	} kwi_pad_t;

	// Live configuration of the detector
	typedef struct packed {
		logic [7:0] pin_enable;
		logic [7:0] polarity;
		logic       detect_mode;
		logic       irq_enable;
	} kwi_cfg_t;

	// Power state as seen by the block
	typedef struct packed {
		logic wait_mode;
		logic light_stop;
		logic deep_stop;
		logic deepest_stop;
		logic bdm_active;
	} kwi_pwr_t;

endpackage

// [design/kwi_regs.svh]
`ifndef KWI_REGS_SVH
`define KWI_REGS_SVH

// Register offsets on the plain register port
`define KWI_ADDR_W            3
`define KWI_OFS_STATUS_CTRL   3'h0
`define KWI_OFS_PIN_ENABLE    3'h1
`define KWI_OFS_POLARITY      3'h2
`define KWI_OFS_INT_STATUS    3'h3
`define KWI_OFS_INT_MASK      3'h4

// status_control_reg fields
`define KWI_SC_DETECT_MODE    0
`define KWI_SC_IRQ_ENABLE     1
`define KWI_SC_FLAG_ACK       2
`define KWI_SC_EVENT_FLAG     3

// int_status / int_mask fields
`define KWI_IS_EDGE           0
`define KWI_IS_LEVEL          1
`define KWI_IS_W              2

// Reset values
`define KWI_RST_PINS          8'h00
`define KWI_RST_IS            2'h0

`endif

// [design/kwi_top.sv]
// What this block does
// RULE1: Eight input pins, each individually enabled
// RULE2: Each enable bit gates only its pin
// RULE3: One mode bit: edge or edge-and-level
// RULE4: Per-pin polarity: falling/low or rising/high
// RULE5: Edges seen between consecutive clock samples
// RULE6: Rearm only when all enabled pins deasserted
// RULE7: Outside holds enabled pins deasserted first
// RULE8: Edge mode: valid edge sets event flag
// RULE9: Level mode: edge or level sets flag
// RULE10: Flag and irq enable raise interrupt
// RULE11: Writing one to acknowledge clears flag
// RULE12: Keeps running in wait mode
// RULE13: Keeps running, wakes from light stop
// RULE14: Deep stops disable and reset block
// RULE15: Debug mode changes nothing
// RULE16: Polarity turns pull-up into pull-down
// RULE17: Held level re-sets flag after acknowledge
// RULE18: Everything resets to zero; the rearm flag armed_q resets to one
`timescale 1ns/100ps
`include "kwi_regs.svh"

module kwi_top #(
	parameter int unsigned NPINS = 8
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Register port
	input  wire logic [`KWI_ADDR_W-1:0]    reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// Key pins and pad control
	input  wire logic [NPINS-1:0]          key_pins,
	input  wire logic [NPINS-1:0]          pull_enable,
	output kwi_pkg::kwi_pad_t              pad_ctrl,
	// Power state
	input  kwi_pkg::kwi_pwr_t              pwr,
	// Interrupt and wake
	output logic                           key_wake_irq,
	output logic                           wake_req
);
	import kwi_pkg::*;

	kwi_cfg_t                cfg_q;
	logic                    event_flag_q;
	logic [`KWI_IS_W-1:0]    int_status_q;
	logic [`KWI_IS_W-1:0]    int_mask_q;
	logic [NPINS-1:0]        pin_q;
	logic                    armed_q;
	logic [7:0]              rdata_q;

	logic                    deep_clr;
	logic [NPINS-1:0]        asserted;
	logic [NPINS-1:0]        pin_edge;
	logic                    edge_hit;
	logic                    level_hit;
	logic                    flag_set;
	logic                    ack;
	logic                    wr_sc;
	logic                    wr_is;
	logic [`KWI_IS_W-1:0]    is_set;
	logic                    wr_mask;
	logic                    any_asserted;
	logic                    any_edge;
	logic                    flag_irq;
	logic                    status_irq;
	logic                    keeps_running;
	logic [`KWI_IS_W-1:0]    is_pending;
	logic [7:0]              sc_view;
	logic [7:0]              rd_mux;

	// Deep stops drop all state except the pin samples and read data; light stop and wait change nothing
	assign deep_clr = pwr.deep_stop | pwr.deepest_stop; // RULE14

	// Address decode, one strobe per register that needs it
	assign wr_sc   = reg_wr && (reg_addr == `KWI_OFS_STATUS_CTRL);
	assign wr_is   = reg_wr && (reg_addr == `KWI_OFS_INT_STATUS);
	assign wr_mask = reg_wr && (reg_addr == `KWI_OFS_INT_MASK);
	assign ack     = wr_sc && reg_wdata[`KWI_SC_FLAG_ACK]; // RULE11

	// Per-pin detection
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++)
		begin : g_pin
			// Asserted level equals the polarity bit
			assign asserted[gi] = cfg_q.pin_enable[gi] & (key_pins[gi] == cfg_q.polarity[gi]); // RULE2 RULE4
			// Deasserted last sample, asserted now
			assign pin_edge[gi] = asserted[gi] & (pin_q[gi] != cfg_q.polarity[gi]); // RULE5
			// Pull-down replaces pull-up for enabled rising/high pins
			assign pad_ctrl.pull_down_en[gi] = pull_enable[gi] & cfg_q.pin_enable[gi]
				& cfg_q.polarity[gi]; // RULE16
			assign pad_ctrl.pull_up_en[gi] = pull_enable[gi]
				& ~(cfg_q.pin_enable[gi] & cfg_q.polarity[gi]); // RULE16
		end
	endgenerate

	assign any_asserted = |asserted;
	assign any_edge     = |pin_edge;
	assign edge_hit     = armed_q & any_edge; // RULE6 RULE8
	// Held level keeps setting the flag, so an ack cannot lose it
	assign level_hit    = cfg_q.detect_mode & any_asserted; // RULE3 RULE9 RULE17
	assign flag_set     = edge_hit | level_hit;
	assign is_set[`KWI_IS_EDGE]  = edge_hit;
	assign is_set[`KWI_IS_LEVEL] = level_hit;

	// Pin sampling; debug mode is deliberately ignored
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			pin_q <= '0;
		else
			pin_q <= key_pins; // RULE5 RULE15
	end

	// Rearm after every enabled pin is back at its deasserted level
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			armed_q <= 1'b1; // RULE7
		else if (deep_clr)
			armed_q <= 1'b1;
		else if (edge_hit)
			armed_q <= 1'b0; // RULE6
		else if (!any_asserted)
			armed_q <= 1'b1; // RULE6
	end

	// Configuration registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cfg_q <= '0; // RULE18
		else if (deep_clr)
			cfg_q <= '0; // RULE14
		else if (reg_wr)
		begin
			unique case (reg_addr)
				`KWI_OFS_STATUS_CTRL:
				begin
					cfg_q.detect_mode <= reg_wdata[`KWI_SC_DETECT_MODE]; // RULE3
					cfg_q.irq_enable  <= reg_wdata[`KWI_SC_IRQ_ENABLE];
				end
				`KWI_OFS_PIN_ENABLE: cfg_q.pin_enable <= reg_wdata[NPINS-1:0]; // RULE1 RULE2
				`KWI_OFS_POLARITY:   cfg_q.polarity   <= reg_wdata[NPINS-1:0]; // RULE4
				default:             cfg_q            <= cfg_q;
			endcase
		end
	end

	// Shared event flag; a new event wins over a same-cycle ack
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			event_flag_q <= 1'b0; // RULE18
		else if (deep_clr)
			event_flag_q <= 1'b0; // RULE14
		else if (flag_set)
			event_flag_q <= 1'b1; // RULE8 RULE9 RULE12 RULE13
		else if (ack)
			event_flag_q <= 1'b0; // RULE11
	end

	// Sticky event causes, write one to clear, set wins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			int_status_q <= `KWI_RST_IS;
		else if (deep_clr)
			int_status_q <= `KWI_RST_IS;
		else if (wr_is)
			int_status_q <= (int_status_q & ~reg_wdata[`KWI_IS_W-1:0]) | is_set;
		else
			int_status_q <= int_status_q | is_set;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			int_mask_q <= `KWI_RST_IS;
		else if (deep_clr)
			int_mask_q <= `KWI_RST_IS;
		else if (wr_mask)
			int_mask_q <= reg_wdata[`KWI_IS_W-1:0];
	end

	// Status and control as software sees it; acknowledge reads zero
	always_comb
	begin
		sc_view                      = 8'h00;
		sc_view[`KWI_SC_EVENT_FLAG]  = event_flag_q;
		sc_view[`KWI_SC_IRQ_ENABLE]  = cfg_q.irq_enable;
		sc_view[`KWI_SC_DETECT_MODE] = cfg_q.detect_mode;
	end

	// Read selection; unmapped offsets and idle cycles give zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`KWI_OFS_STATUS_CTRL: rd_mux = sc_view;
				`KWI_OFS_PIN_ENABLE:  rd_mux = 8'(cfg_q.pin_enable);
				`KWI_OFS_POLARITY:    rd_mux = 8'(cfg_q.polarity);
				`KWI_OFS_INT_STATUS:  rd_mux = {6'h00, int_status_q};
				`KWI_OFS_INT_MASK:    rd_mux = {6'h00, int_mask_q};
				default:              rd_mux = 8'h00;
			endcase
		end
	end

	// Read data valid in the cycle after the strobe only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rd_mux;
	end

	assign reg_rdata = rdata_q;

	// Interrupt level; also the wake request in wait and light stop
	assign is_pending    = int_status_q & int_mask_q;
	assign flag_irq      = event_flag_q & cfg_q.irq_enable; // RULE10
	assign status_irq    = |is_pending;
	assign key_wake_irq  = flag_irq | status_irq; // RULE10
	// Debug mode is not a low-power state, so it never asks for a wake
	assign keeps_running = pwr.wait_mode | pwr.light_stop;
	assign wake_req      = key_wake_irq & keeps_running; // RULE12 RULE13

endmodule // kwi_top

// [dv/kwi_keys.sv]
`timescale 1ns/100ps
module kwi_keys (
	// Clock
	input wire logic        ref_clk,
	// Switch control
	input wire logic [7:0]  press,
	input wire logic [7:0]  pol,
	// Pins toward the block
	output logic     [7:0]  key_pins = 8'hFF
);
	// Released switch rests at the deasserted level
	always @(posedge ref_clk)
		key_pins <= ~(press ^ pol);
endmodule // kwi_keys

// [dv/kwi_top_monitor.sv]
`timescale 1ns/100ps
module kwi_top_monitor #(
	parameter int unsigned NPINS = 8
) (
	// Clock and reset
	input wire logic             ref_clk,
	input wire logic             rst,
	// Watched ports
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata,
	input wire logic [NPINS-1:0] pull_enable,
	input kwi_pkg::kwi_pad_t     pad_ctrl,
	input kwi_pkg::kwi_pwr_t     pwr,
	input wire logic             key_wake_irq,
	input wire logic             wake_req
);
	import kwi_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_wake; wake_req == (key_wake_irq && (pwr.wait_mode || pwr.light_stop)); endproperty
	a_wake: assert property (p_wake) else $error("wake request wrong");
	property p_deep; pwr.deep_stop |=> !key_wake_irq; endproperty
	a_deep: assert property (p_deep) else $error("irq survives deep stop");
	property p_deepest; pwr.deepest_stop |=> pad_ctrl.pull_down_en == 8'h00; endproperty
	a_deepest: assert property (p_deepest) else $error("config survives deepest stop");
	property p_pad_excl; (pad_ctrl.pull_up_en & pad_ctrl.pull_down_en) == 8'h00; endproperty
	a_pad_excl: assert property (p_pad_excl) else $error("pull up and down together");
	property p_pad_sum; (pad_ctrl.pull_up_en | pad_ctrl.pull_down_en) == pull_enable; endproperty
	a_pad_sum: assert property (p_pad_sum) else $error("pull device lost");
	property p_rst_quiet; $fell(rst) |-> !key_wake_irq && !wake_req; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("irq after reset");
	// Sticky: only a write or a deep stop may drop the request
	property p_irq_hold; key_wake_irq && !reg_wr && !pwr.deep_stop && !pwr.deepest_stop |=> key_wake_irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
	c_wake: cover property (wake_req);
	c_irq: cover property ($rose(key_wake_irq));
	c_pull_down: cover property (pad_ctrl.pull_down_en != 8'h00);
endmodule // kwi_top_monitor

bind kwi_top kwi_top_monitor #(.NPINS(NPINS)) mon (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_rdata, .pull_enable,
	.pad_ctrl, .pwr, .key_wake_irq, .wake_req);

// [dv/kwi_top_tb.sv]
`timescale 1ns/100ps
module kwi_top_tb;
	import kwi_pkg::*;
	logic       ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, key_wake_irq, wake_req;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, pull_enable = 8'h00, press = 8'h00, pol = 8'h00, reg_rdata, key_pins;
	kwi_pad_t   pad_ctrl;
	kwi_pwr_t   pwr = 5'h00;
	int         fail_count = 0, cmp_count = 0, cyc = 0;
	kwi_top dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .key_pins, .pull_enable,
		.pad_ctrl, .pwr, .key_wake_irq, .wake_req);
	kwi_keys keys (.ref_clk, .press, .pol, .key_pins);
	initial forever #5 ref_clk = ~ref_clk;
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd(logic [2:0] a, logic [7:0] e);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 chk("rdata", reg_rdata, e);
		@(posedge ref_clk);
	endtask
	task automatic hold(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic t_edge;
		wr(3'h1, 8'h01);
		wr(3'h4, 8'h01);
		press <= 8'h02;
		hold(3);
		chk("irq", key_wake_irq, 1'h0);
		press <= 8'h03;
		hold(3);
		chk("irq", key_wake_irq, 1'h1);
		rd(3'h0, 8'h08);
		wr(3'h4, 8'h00);
		chk("irq", key_wake_irq, 1'h0);
		wr(3'h0, 8'h02);
		chk("irq", key_wake_irq, 1'h1);
		wr(3'h1, 8'h03);
		wr(3'h0, 8'h06);
		wr(3'h3, 8'h03);
		rd(3'h0, 8'h02);
		press <= 8'h02;
		hold(2);
		press <= 8'h03;
		hold(3);
		rd(3'h0, 8'h02);
		press <= 8'h00;
		hold(2);
		press <= 8'h01;
		hold(3);
		rd(3'h0, 8'h0A);
		wr(3'h0, 8'h04);
		press <= 8'h00;
		$display("edge test done");
	endtask
	task automatic t_level;
		pol <= 8'h04;
		pull_enable <= 8'hFF;
		pwr <= 5'h01;
		wr(3'h2, 8'h04);
		wr(3'h1, 8'h04);
		wr(3'h0, 8'h01);
		chk("pad", pad_ctrl, 16'hFB04);
		press <= 8'h04;
		hold(3);
		rd(3'h0, 8'h09);
		rd(3'h3, 8'h03);
		wr(3'h0, 8'h05);
		rd(3'h0, 8'h09);
		press <= 8'h00;
		hold(3);
		wr(3'h0, 8'h05);
		rd(3'h0, 8'h01);
		pwr <= 5'h00;
		$display("level test done");
	endtask
	task automatic t_power;
		wr(3'h0, 8'h02);
		press <= 8'h04;
		hold(3);
		pwr <= 5'h10;
		hold(1);
		chk("wake", wake_req, 1'h1);
		pwr <= 5'h08;
		hold(1);
		chk("wake", wake_req, 1'h1);
		pwr <= 5'h06;
		hold(2);
		pwr <= 5'h00;
		press <= 8'h00;
		rd(3'h1, 8'h00);
		chk("irq", key_wake_irq, 1'h0);
		$display("power test done");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Whole run needs about 100 cycles
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			fail_count++;
			wrap_up;
		end
	end
	initial
	begin
		hold(10);
		rst <= 1'h0;
		hold(1);
		for (int a = 0; a < 6; a++)
			rd(a[2:0], 8'h00);
		t_edge;
		t_level;
		t_power;
		wrap_up;
	end
endmodule // kwi_top_tb
